// *** design/count_tick_gen.sv ***
// Purpose: Count clock enable from the selected prescaler tap
// Assumes: Runs on aclk; sel picks a power-of-two divide
// Notes:   One-cycle tick pulses, held high every cycle for sel 0; cleared while not running
`timescale 1ns/10ps
module count_tick_gen #(
  parameter int DIV_W = 12
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);

  logic [DIV_W-1:0] div_q;
  logic             tap;

  always_comb begin
    unique case (sel)
      3'h0: tap = 1'b1;
      3'h1: tap = &div_q[1:0];
      3'h2: tap = &div_q[3:0];
      3'h3: tap = &div_q[5:0];
      3'h4: tap = &div_q[DIV_W-1:0];
      3'h5: tap = &div_q[6:0];
      3'h6: tap = &div_q[8:0];
      3'h7: tap = &div_q[2:0];
    endcase
  end

  // Divider restarts on each run so the first count clock is a whole period
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      tick <= 1'b0;
    end else begin
      tick <= tap;
    end
  end

endmodule

// *** design/pwm_carrier_timer.sv ***
// Purpose: 8-bit timer channel with PWM and infrared carrier modes, AXI4-Lite registers
// Assumes: Single clock aclk, synchronous active-low reset, partner irq synchronous pulse
// Notes:   Interval mode toggles on period matches only
`timescale 1ns/10ps
`include "pwm_carrier_timer_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Period match clears, irqs, toggles, selects duty in PWM and carrier modes
// - PWM duty match toggles, reselects period only
// - PWM period N+1, duty (M+1)/(N+1)
// - Duty write buffered, transfers at a duty match once aged three count clocks
// - Start masks first clock, pin idle outside carrier mode
// - Stopping returns irq and pin idle
// - Carrier: period low width, duty high
// - Remote enable and master select output
// - Gate master writable, slave read-only
// - Partner irq synced to count clock
// - Slave copies master second clock after
// - Idle level select chooses pin default
module pwm_carrier_timer #(
  parameter int DIV_W = 12
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        partner_timer_irq,
  output logic             timer_out_pin,
  output logic             match_irq,
  output logic             synced_partner_irq
);

  pwm_carrier_timer_pkg::mode_reg_t    timer_mode_reg_q;
  pwm_carrier_timer_pkg::carrier_reg_t carrier_control_reg_q;
  logic [7:0] period_compare_q;
  logic [7:0] duty_compare_q;
  logic [7:0] duty_buf_q;
  logic       duty_pend_q;
  logic [1:0] duty_age_q;
  logic [7:0] count_q;
  logic       cmp_duty_q;
  logic       started_q;
  logic       wave_q;
  logic       partner_pend_q;
  logic [1:0] gate_cnt_q;
  logic       tick;
  logic       run;
  logic       aw_held_q;
  logic       w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       wr_go;
  logic       duty_wr;
  logic       period_hit;
  logic       duty_hit;
  logic       cmp_hit;
  logic       pwm_mode;
  logic       car_mode;

  assign run      = timer_mode_reg_q.run;
  assign pwm_mode = timer_mode_reg_q.md == pwm_carrier_timer_pkg::MODE_PWM;
  assign car_mode = timer_mode_reg_q.md == pwm_carrier_timer_pkg::MODE_CARRIER;

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    merge_byte = s[0] ? d[7:0] : old;
  endfunction

  count_tick_gen #(
    .DIV_W (DIV_W)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (run),
    .sel     (timer_mode_reg_q.cks),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data accepted in either order
  assign wr_go   = aw_held_q && w_held_q && !s_axi_bvalid;
  assign duty_wr = wr_go && (aw_addr_q == `OFS_DUTY) && w_strb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Unmapped or read-only targets still answer OKAY; writes to them are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= 2'h0;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_mode_reg_q <= `RESET_MODE;
    end else if (wr_go && aw_addr_q == `OFS_MODE && w_strb_q[0]) begin
      timer_mode_reg_q <= w_data_q[7:0];
    end
  end

  // Period held by software while running, no hardware guard
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_compare_q <= `RESET_PERIOD;
    end else if (wr_go && aw_addr_q == `OFS_PERIOD) begin
      period_compare_q <= merge_byte(period_compare_q, w_data_q, w_strb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier_control_reg_q.remote <= 1'b0;
      carrier_control_reg_q.master <= 1'b0;
    end else if (wr_go && aw_addr_q == `OFS_CARRIER && w_strb_q[0]) begin
      carrier_control_reg_q.remote <= w_data_q[`CAR_REMOTE_BIT];
      carrier_control_reg_q.master <= w_data_q[`CAR_MASTER_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Duty buffer: stopped writes go straight through, running writes wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_buf_q  <= `RESET_DUTY;
      duty_pend_q <= 1'b0;
      duty_age_q  <= 2'h0;
    end else if (duty_wr) begin
      duty_buf_q  <= w_data_q[7:0];
      duty_pend_q <= run;
      duty_age_q  <= 2'h0;
    end else if (duty_pend_q && tick && cmp_duty_q && duty_hit
                 && duty_age_q == `DUTY_SETTLE_CLKS) begin
      duty_pend_q <= 1'b0;
    end else if (duty_pend_q && tick && duty_age_q != `DUTY_SETTLE_CLKS) begin
      duty_age_q <= duty_age_q + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_compare_q <= `RESET_DUTY;
    end else if (duty_wr && !run) begin
      duty_compare_q <= w_data_q[7:0];
    end else if (duty_pend_q && tick && cmp_duty_q && duty_hit
                 && duty_age_q == `DUTY_SETTLE_CLKS) begin
      duty_compare_q <= duty_buf_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and compare selection
  assign period_hit = count_q == period_compare_q;
  assign duty_hit   = count_q == duty_compare_q;
  assign cmp_hit    = started_q && (cmp_duty_q ? duty_hit : period_hit);

  // First count clock after start is swallowed
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      started_q <= 1'b0;
    end else if (tick) begin
      started_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count_q <= 8'h00;
    end else if (tick && started_q) begin
      if (cmp_hit && (!cmp_duty_q || !pwm_mode)) begin
        count_q <= 8'h00;
      end else begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cmp_duty_q <= 1'b0;
    end else if (tick && cmp_hit && (pwm_mode || car_mode)) begin
      cmp_duty_q <= !cmp_duty_q;
    end
  end

  // Internal waveform starts low, pin maps it onto the idle level outside carrier mode
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      wave_q <= 1'b0;
    end else if (tick && cmp_hit) begin
      wave_q <= !wave_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      match_irq <= 1'b0;
    end else begin
      match_irq <= tick && cmp_hit && (!cmp_duty_q || !pwm_mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Partner interrupt held until the next count clock, then slave gate copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      partner_pend_q <= 1'b0;
    end else if (partner_timer_irq && !tick) begin
      // An irq that meets a tick is consumed at once, so it must not also stay pending
      partner_pend_q <= 1'b1;
    end else if (tick) begin
      partner_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      synced_partner_irq <= 1'b0;
    end else begin
      synced_partner_irq <= tick && (partner_pend_q || partner_timer_irq);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_cnt_q <= 2'h0;
    end else if (synced_partner_irq) begin
      gate_cnt_q <= 2'h1;
    end else if (tick && gate_cnt_q != 2'h0) begin
      gate_cnt_q <= (gate_cnt_q == `GATE_COPY_CLKS) ? 2'h0 : gate_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier_control_reg_q.slave <= 1'b0;
    end else if (tick && gate_cnt_q == `GATE_COPY_CLKS) begin
      carrier_control_reg_q.slave <= carrier_control_reg_q.master;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin select; a disabled output rests at the idle level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_out_pin <= 1'b0;
    end else if (!timer_mode_reg_q.outen || !run) begin
      timer_out_pin <= timer_mode_reg_q.level;
    end else if (car_mode) begin
      if (!carrier_control_reg_q.remote) begin
        timer_out_pin <= carrier_control_reg_q.master;
      end else begin
        timer_out_pin <= carrier_control_reg_q.slave && wave_q;
      end
    end else begin
      timer_out_pin <= wave_q ^ timer_mode_reg_q.level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        unique case (s_axi_araddr)
          `OFS_MODE:    s_axi_rdata <= {24'h000000, timer_mode_reg_q};
          `OFS_PERIOD:  s_axi_rdata <= {24'h000000, period_compare_q};
          `OFS_DUTY:    s_axi_rdata <= {24'h000000, duty_compare_q};
          `OFS_CARRIER: s_axi_rdata <= {29'h00000000, carrier_control_reg_q};
          `OFS_STATUS:  s_axi_rdata <= {22'h000000, duty_pend_q, cmp_duty_q, count_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_irq_only_period: assert property (@(posedge aclk) disable iff (!aresetn)
    (pwm_mode && tick && cmp_hit && cmp_duty_q) |=> !match_irq)
    else $error("match irq raised on a PWM duty match");
  a_period_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && tick && cmp_hit && !cmp_duty_q) |=> (count_q == 8'h00) && cmp_duty_q && match_irq)
    else $error("period match did not clear and switch");
  a_stop_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (!run) |=> !match_irq && (count_q == 8'h00))
    else $error("stop did not idle the timer");
  a_first_masked: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(run)) |=> !started_q && (count_q == 8'h00))
    else $error("first count clock not masked");
  a_gate_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && gate_cnt_q == 2'h2)
      |=> carrier_control_reg_q.slave == $past(carrier_control_reg_q.master))
    else $error("gate slave did not take master");
  a_sync_on_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    synced_partner_irq |-> $past(tick))
    else $error("synced partner irq not on a count clock");
  a_duty_settle: assert property (@(posedge aclk) disable iff (!aresetn)
    (duty_pend_q && duty_age_q != 2'h3)
      |=> duty_compare_q == $past(duty_compare_q) || $past(duty_wr))
    else $error("duty transferred too early");
  a_remote_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && car_mode && timer_mode_reg_q.outen && !carrier_control_reg_q.remote)
      |=> timer_out_pin == $past(carrier_control_reg_q.master))
    else $error("remote disabled output wrong");

endmodule

// *** include/pwm_carrier_timer_pkg.sv ***
// Purpose: Types shared by the PWM/carrier timer
// Assumes: Constants live in pwm_carrier_timer_regs.svh
// Notes:   Types only
package pwm_carrier_timer_pkg;

  typedef enum logic [1:0] {
    MODE_INTERVAL = 2'h0,
    MODE_CARRIER  = 2'h1,
    MODE_PWM      = 2'h2,
    MODE_BAD      = 2'h3
  } timer_mode_t;

  typedef struct packed {
    logic        run;
    logic [2:0]  cks;
    timer_mode_t md;
    logic        level;
    logic        outen;
  } mode_reg_t;

  typedef struct packed {
    logic remote;
    logic master;
    logic slave;
  } carrier_reg_t;

endpackage

// *** include/pwm_carrier_timer_regs.svh ***
// Purpose: Register offsets, fields, reset values and timing counts of the PWM/carrier timer
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef PWM_CARRIER_TIMER_REGS_SVH
`define PWM_CARRIER_TIMER_REGS_SVH

`define OFS_MODE      8'h00
`define OFS_PERIOD    8'h04
`define OFS_DUTY      8'h08
`define OFS_CARRIER   8'h0C
`define OFS_STATUS    8'h10

// Mode register fields
`define MODE_RUN_BIT      7
`define MODE_CKS_LSB      4
`define MODE_MD_LSB       2
`define MODE_LEVEL_BIT    1
`define MODE_OUTEN_BIT    0

// Carrier control register fields
`define CAR_REMOTE_BIT    2
`define CAR_MASTER_BIT    1
`define CAR_SLAVE_BIT     0

`define RESET_MODE        8'h00
`define RESET_PERIOD      8'h00
`define RESET_DUTY        8'h00
`define RESET_CARRIER     3'h0

// Count clocks a buffered duty write must age before transfer
`define DUTY_SETTLE_CLKS  2'h3
// Count clock after the synced partner edge at which the gate copies
`define GATE_COPY_CLKS    2'h2

`endif

// *** verification/pin_load_model.sv ***
// Purpose: Load on the timer output pin, measures its level widths
// Assumes: Widths counted in aclk cycles at the rising edge
// Notes:   A width is only valid once the following edge has passed
`timescale 1ns/10ps
module pin_load_model (
  input  wire logic aclk,
  input  wire logic pin,
  output int        hi_w,
  output int        lo_w,
  output int        edges
);
  logic last_q;
  int   run_q;

  initial begin
    hi_w   = 0;
    lo_w   = 0;
    edges  = 0;
    run_q  = 0;
    last_q = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A level is only known complete when the opposite edge arrives
  always @(posedge aclk) begin
    if (pin !== last_q) begin
      if (last_q) hi_w <= run_q;
      else lo_w <= run_q;
      edges <= edges + 1;
      run_q <= 1;
    end else begin
      run_q <= run_q + 1;
    end
    last_q <= pin;
  end
endmodule

// *** verification/tb_pwm_carrier_timer.sv ***
// Purpose: Self-checking bench for the PWM/carrier timer
// Assumes: Count clock select 0 divides by one, select 1 by four
// Notes:   Read results are checked by a monitor against a queue of notes
`timescale 1ns/10ps
`include "pwm_carrier_timer_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_pwm_carrier_timer;
  logic        aclk, aresetn, partner_timer_irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        timer_out_pin, match_irq, synced_partner_irq;
  int          hi_w, lo_w, edges, mismatches, tests_run;
  logic [33:0] exp_q[$];
  logic [33:0] exp_v;
  logic [15:0] lfsr_q;
  pwm_carrier_timer_pkg::mode_reg_t md;

  // Short prescaler tap keeps the slow select usable in simulation
  pwm_carrier_timer #(.DIV_W(4)) pwm_carrier_timer_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .partner_timer_irq(partner_timer_irq), .timer_out_pin(timer_out_pin),
    .match_irq(match_irq), .synced_partner_irq(synced_partner_irq));
  pin_load_model pin_load_model_i (.aclk(aclk), .pin(timer_out_pin), .hi_w(hi_w),
    .lo_w(lo_w), .edges(edges));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task rnd(output logic [7:0] v);
    lfsr_q = lfsr_next(lfsr_q);
    v = lfsr_q[7:0];
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    `CHK({s_axi_bvalid, s_axi_bresp}, 3'h4)
  endtask

  task axi_rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rvalid, 1'b1)
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_q.size() > 0) begin
      // Pop once: the check macro evaluates its expected argument twice
      exp_v = exp_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, exp_v)
    end
  end

  task wait_edges(input int k);
    int t0, n;
    t0 = edges;
    n = 0;
    while (edges < t0 + k && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    `CHK(edges >= t0 + k, 1'b1)
  endtask

  task pulse_irq;
    int n;
    n = 0;
    @(posedge aclk);
    partner_timer_irq <= 1'b1;
    @(posedge aclk);
    partner_timer_irq <= 1'b0;
    while (synced_partner_irq !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    `CHK(synced_partner_irq, 1'b1)
  endtask

  task run_mode(input pwm_carrier_timer_pkg::timer_mode_t t, input logic [2:0] sel,
                input logic lvl, input logic run);
    md = '{run: run, cks: sel, md: t, level: lvl, outen: 1'b1};
    axi_wr(`OFS_MODE, {24'h0, md});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task test_regs;
    `CHK(timer_out_pin, 1'b0)
    for (int i = 0; i < 4; i++) axi_rd(8'(4 * i), 34'h0);
    axi_wr(`OFS_CARRIER, 32'h7);
    axi_rd(`OFS_CARRIER, 34'h6);
    axi_wr(8'h14, 32'hFF);
    axi_rd(8'h14, {2'h2, 32'h0});
    axi_wr(`OFS_CARRIER, 32'h0);
    $display("test regs done");
  endtask

  task test_pwm;
    logic [7:0] n, m;
    logic       lvl;
    int         k, irqs;
    for (int i = 0; i < 3; i++) begin
      rnd(n);
      n = 8'h03 + (n % 8'h28);
      rnd(m);
      m = m % n;
      lvl = i[0];
      k = (i == 2) ? 4 : 1;
      axi_wr(`OFS_PERIOD, {24'h0, n});
      axi_wr(`OFS_DUTY, {24'h0, m});
      run_mode(pwm_carrier_timer_pkg::MODE_PWM, (i == 2) ? 3'h1 : 3'h0, lvl, 1'b1);
      // Pin takes the new idle level one edge after the mode write lands
      @(posedge aclk);
      `CHK(timer_out_pin, lvl)
      wait_edges(4);
      `CHK(hi_w, lvl ? k * (n - m) : k * (m + 1))
      `CHK(lo_w, lvl ? k * (m + 1) : k * (n - m))
      irqs = 0;
      repeat (k * (n + 1)) begin
        @(posedge aclk);
        if (match_irq === 1'b1) irqs++;
      end
      `CHK(irqs, 1)
      run_mode(pwm_carrier_timer_pkg::MODE_PWM, md.cks, lvl, 1'b0);
      @(posedge aclk);
      `CHK({timer_out_pin, match_irq}, {lvl, 1'b0})
    end
    $display("test pwm done");
  endtask

  task test_duty;
    axi_wr(`OFS_PERIOD, 32'h14);
    axi_wr(`OFS_DUTY, 32'h04);
    run_mode(pwm_carrier_timer_pkg::MODE_PWM, 3'h0, 1'b0, 1'b1);
    wait_edges(3);
    axi_wr(`OFS_DUTY, 32'h0A);
    wait_edges(6);
    `CHK(hi_w, 11)
    `CHK(lo_w, 10)
    run_mode(pwm_carrier_timer_pkg::MODE_PWM, 3'h0, 1'b0, 1'b0);
    $display("test duty done");
  endtask

  task test_carrier;
    axi_wr(`OFS_PERIOD, 32'h05);
    axi_wr(`OFS_DUTY, 32'h02);
    // Fastest count clock keeps the single partner pulse far slower
    run_mode(pwm_carrier_timer_pkg::MODE_CARRIER, 3'h0, 1'b0, 1'b1);
    axi_wr(`OFS_CARRIER, 32'h2);
    repeat (2) @(posedge aclk);
    `CHK(timer_out_pin, 1'b1)
    axi_wr(`OFS_CARRIER, 32'h0);
    repeat (2) @(posedge aclk);
    `CHK(timer_out_pin, 1'b0)
    axi_wr(`OFS_CARRIER, 32'h6);
    pulse_irq();
    axi_rd(`OFS_CARRIER, 34'h7);
    wait_edges(4);
    `CHK(hi_w, 3)
    `CHK(lo_w, 6)
    axi_wr(`OFS_CARRIER, 32'h4);
    pulse_irq();
    axi_rd(`OFS_CARRIER, 34'h4);
    repeat (12) @(posedge aclk);
    `CHK(timer_out_pin, 1'b0)
    run_mode(pwm_carrier_timer_pkg::MODE_CARRIER, 3'h0, 1'b0, 1'b0);
    $display("test carrier done");
  endtask

  task summarize;
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    {aresetn, partner_timer_irq, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
    s_axi_wstrb = 4'hF;
    mismatches  = 0;
    tests_run   = 0;
    lfsr_q      = 16'hAC0D;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_pwm();
    test_duty();
    test_carrier();
    summarize();
  end
endmodule
